// File: swf_cmp_if.sv
// carrier between the derating top and its hysteresis comparators
`timescale 1ns/1ps
`default_nettype none
interface swf_cmp_if #(
    parameter int W = 16
);
    logic [W-1:0] value;
    logic [W-1:0] up_thr;
    logic [W-1:0] dn_thr;
    logic above;

    modport cmp (
        input value,
        input up_thr,
        input dn_thr,
        output above
    );
    modport user (
        output value,
        output up_thr,
        output dn_thr,
        input above
    );
endinterface
`default_nettype wire

// File: swf_derate.sv
// effective switching frequency selection with temperature, speed and current derating
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R1] hotter heatsink lowers effective switching frequency below the setting
// [R2] low-speed reduction ends above 9/7/5/3 Hz for 32/24/16/12 kHz settings
// [R3] low-speed reduction starts below 7/5/3/1 Hz for 32/24/16/12 kHz
// [R4] separate up and down speed thresholds give hysteresis
// [R5] variant, 12/16/24 kHz: above 10.45 A go 8 kHz, below 7.6 A restore
// [R6] variant, 32 kHz: above 10.45 A 8 kHz, below 7.6 A 24, below 6.7 A 32
// [R7] other models: above 140% rated go 8 kHz, below 110% restore
// [R8] the lowest frequency asked by any condition wins
module swf_derate
    import swf_pkg::*;
#(
    parameter int FREQ_W = 16,
    parameter int CUR_W = 16,
    parameter int TEMP_W = 16,
    parameter int NUM_TEMP_LVL = 2
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // configuration
    input wire logic [2:0] set_code_i,
    input wire logic variant_i,
    input wire logic [CUR_W-1:0] rated_cur_i,
    // measurements
    input wire logic [FREQ_W-1:0] out_freq_i,
    input wire logic [CUR_W-1:0] motor_cur_i,
    input wire logic [TEMP_W-1:0] temp_i,
    // result
    output logic [2:0] eff_code_o,
    output logic lf_reduced_o,
    output logic cur_reduced_o,
    output logic [2:0] temp_level_o
);
    // ----------------------------------------------------------------
    // low output frequency
    // ----------------------------------------------------------------
    logic lf_on;
    logic lf_high;
    logic [2:0] lf_cap;
    swf_cmp_if #(.W(FREQ_W)) lf_if ();

    assign lf_on = swf_lf_applies(set_code_i);
    assign lf_if.value = out_freq_i;
    assign lf_if.up_thr = FREQ_W'(swf_lf_up(set_code_i)); // R2
    assign lf_if.dn_thr = FREQ_W'(swf_lf_dn(set_code_i)); // R3
    assign lf_high = lf_if.above;
    // reduced speed drops to 8 kHz; flag starts low so a drive at rest is reduced
    assign lf_cap = (lf_on && !lf_high) ? SWF_CODE_8K : SWF_CODE_32K; // R3

    swf_hyst u_lf (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .cmp(lf_if.cmp)
    ); // R4

    // ----------------------------------------------------------------
    // heatsink temperature levels
    // ----------------------------------------------------------------
    logic [NUM_TEMP_LVL-1:0] temp_hot;
    logic [2:0] temp_cnt;
    logic [2:0] temp_cap;

    for (genvar g = 0; g < NUM_TEMP_LVL; g++) begin : g_temp
        swf_cmp_if #(.W(TEMP_W)) t_if ();
        assign t_if.value = temp_i;
        assign t_if.up_thr = TEMP_W'(SWF_TEMP_BASE + 16'(g) * SWF_TEMP_STEP);
        assign t_if.dn_thr = TEMP_W'(SWF_TEMP_BASE + 16'(g) * SWF_TEMP_STEP - SWF_TEMP_HYST);
        assign temp_hot[g] = t_if.above;
        swf_hyst u_t (
            .clk_i(clk_i),
            .reset_n_i(reset_n_i),
            .ce_i(ce_i),
            .cmp(t_if.cmp)
        );
    end

    always_comb begin
        temp_cnt = 3'h0;
        for (int i = 0; i < NUM_TEMP_LVL; i++) begin
            temp_cnt = temp_cnt + 3'(temp_hot[i]);
        end
    end
    // each level passed takes one step down, floored at the lowest setting
    assign temp_cap = (set_code_i > temp_cnt) ? 3'(set_code_i - temp_cnt) : SWF_CODE_4K; // R1

    // ----------------------------------------------------------------
    // motor current
    // ----------------------------------------------------------------
    swf_cur_state_type cur_state;
    swf_cur_state_type next_cur_state;
    logic [CUR_W+7:0] cur_scaled;
    logic [CUR_W+7:0] rated_trip;
    logic [CUR_W+7:0] rated_back;
    logic trip;
    logic [2:0] cur_cap;

    // percent compare done as products so no divider is needed
    assign cur_scaled = (CUR_W+8)'(motor_cur_i) * (CUR_W+8)'(SWF_PCT_UNIT);
    assign rated_trip = (CUR_W+8)'(rated_cur_i) * (CUR_W+8)'(SWF_PCT_TRIP);
    assign rated_back = (CUR_W+8)'(rated_cur_i) * (CUR_W+8)'(SWF_PCT_BACK);
    assign trip = variant_i ? (motor_cur_i > CUR_W'(SWF_CUR_TRIP)) : (cur_scaled > rated_trip);

    always_comb begin
        next_cur_state = cur_state;
        case (cur_state)
            SWF_CUR_AT_SET: begin
                if (trip) begin
                    next_cur_state = SWF_CUR_AT_8K; // R5 R7
                end
            end
            SWF_CUR_AT_8K: begin
                if (!variant_i) begin
                    if (cur_scaled < rated_back) begin
                        next_cur_state = SWF_CUR_AT_SET; // R7
                    end
                end else if (set_code_i == SWF_CODE_32K) begin
                    if (motor_cur_i < CUR_W'(SWF_CUR_FULL)) begin
                        next_cur_state = SWF_CUR_AT_SET; // R6
                    end else if (motor_cur_i < CUR_W'(SWF_CUR_MID)) begin
                        next_cur_state = SWF_CUR_AT_24K; // R6
                    end
                end else if (motor_cur_i < CUR_W'(SWF_CUR_MID)) begin
                    next_cur_state = SWF_CUR_AT_SET; // R5
                end
            end
            SWF_CUR_AT_24K: begin
                if (trip) begin
                    next_cur_state = SWF_CUR_AT_8K; // R6
                end else if (!variant_i || motor_cur_i < CUR_W'(SWF_CUR_FULL)) begin
                    next_cur_state = SWF_CUR_AT_SET; // R6
                end
            end
            default: next_cur_state = SWF_CUR_AT_SET;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur_state <= SWF_CUR_AT_SET;
        end else if (ce_i) begin
            cur_state <= next_cur_state;
        end
    end

    always_comb begin
        case (cur_state)
            SWF_CUR_AT_8K: cur_cap = SWF_CODE_8K;
            SWF_CUR_AT_24K: cur_cap = SWF_CODE_24K;
            default: cur_cap = SWF_CODE_32K;
        endcase
    end

    // ----------------------------------------------------------------
    // combine and register
    // ----------------------------------------------------------------
    logic [2:0] next_eff;

    always_comb begin
        next_eff = set_code_i;
        if (lf_cap < next_eff) begin
            next_eff = lf_cap; // R8
        end
        if (cur_cap < next_eff) begin
            next_eff = cur_cap; // R8
        end
        if (temp_cap < next_eff) begin
            next_eff = temp_cap; // R8
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            eff_code_o <= SWF_RESET_CODE;
            lf_reduced_o <= 1'b0;
            cur_reduced_o <= 1'b0;
            temp_level_o <= 3'h0;
        end else if (ce_i) begin
            eff_code_o <= next_eff;
            lf_reduced_o <= lf_on && !lf_high;
            cur_reduced_o <= (cur_state != SWF_CUR_AT_SET);
            temp_level_o <= temp_cnt;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_eff_never_above: assert property ( // R8
        ce_i |=> eff_code_o <= $past(set_code_i)
    ) else $error("effective code above the setting");

    a_temp_steps_down: assert property ( // R1
        ce_i && temp_cnt != 3'h0 && set_code_i != SWF_CODE_4K |=> eff_code_o < $past(set_code_i)
    ) else $error("hot heatsink did not lower the frequency");

    a_lf_reduce_low: assert property ( // R3
        ce_i && lf_on && out_freq_i < lf_if.dn_thr ##1 ce_i && $stable(set_code_i)
        |=> lf_reduced_o && eff_code_o <= SWF_CODE_8K
    ) else $error("low speed did not reduce switching");

    a_lf_restore_high: assert property ( // R2
        ce_i && out_freq_i > lf_if.up_thr ##1 ce_i |=> !lf_reduced_o
    ) else $error("speed above upper threshold still reduced");

    a_lf_band_hold: assert property ( // R4
        ce_i && out_freq_i >= lf_if.dn_thr && out_freq_i <= lf_if.up_thr
        |=> lf_high == $past(lf_high)
    ) else $error("flag moved inside the hysteresis band");

    a_var_trip_8k: assert property ( // R5
        ce_i && variant_i && motor_cur_i > CUR_W'(SWF_CUR_TRIP) |=> cur_state == SWF_CUR_AT_8K
    ) else $error("variant overcurrent did not go to 8 kHz");

    a_var_step_24k: assert property ( // R6
        ce_i && variant_i && set_code_i == SWF_CODE_32K && cur_state == SWF_CUR_AT_8K
        && motor_cur_i < CUR_W'(SWF_CUR_MID) && motor_cur_i >= CUR_W'(SWF_CUR_FULL)
        |=> cur_state == SWF_CUR_AT_24K ##1 (!ce_i || cur_reduced_o)
    ) else $error("32 kHz setting did not step to 24 kHz");

    a_var_full_back: assert property ( // R6
        ce_i && variant_i && cur_state != SWF_CUR_AT_SET && motor_cur_i < CUR_W'(SWF_CUR_FULL)
        |=> cur_state == SWF_CUR_AT_SET
    ) else $error("low current did not restore the setting");

    a_other_trip: assert property ( // R7
        ce_i && !variant_i && cur_scaled > rated_trip |=> cur_state == SWF_CUR_AT_8K
    ) else $error("overcurrent above 140 percent not derated");

    a_other_back: assert property ( // R7
        ce_i && !variant_i && cur_state == SWF_CUR_AT_8K && cur_scaled < rated_back
        |=> cur_state == SWF_CUR_AT_SET
    ) else $error("current below 110 percent not restored");

    c_step_24k: cover property (cur_state == SWF_CUR_AT_8K ##1 cur_state == SWF_CUR_AT_24K);
    c_lf_cycle: cover property (lf_reduced_o ##[1:50] !lf_reduced_o);
    c_temp_two: cover property (temp_level_o == 3'h2);
    c_eff_4k: cover property (eff_code_o == SWF_CODE_4K && set_code_i == SWF_CODE_12K);

endmodule
`default_nettype wire

// File: swf_hyst.sv
// two-threshold comparator: sets above the upper, clears below the lower
`timescale 1ns/1ps
`default_nettype none
module swf_hyst
    import swf_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // comparison
    swf_cmp_if.cmp cmp
);
    // between the two thresholds the flag holds, so no chatter near one level
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmp.above <= 1'b0;
        end else if (ce_i) begin
            if (cmp.value > cmp.up_thr) begin
                cmp.above <= 1'b1;
            end else if (cmp.value < cmp.dn_thr) begin
                cmp.above <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: swf_pkg.sv
// constants and lookup helpers for the switching frequency derating block
package swf_pkg;

    // ----------------------------------------------------------------
    // switching frequency setting codes, ascending frequency
    // ----------------------------------------------------------------
    localparam logic [2:0] SWF_CODE_4K = 3'h0;
    localparam logic [2:0] SWF_CODE_8K = 3'h1;
    localparam logic [2:0] SWF_CODE_12K = 3'h2;
    localparam logic [2:0] SWF_CODE_16K = 3'h3;
    localparam logic [2:0] SWF_CODE_24K = 3'h4;
    localparam logic [2:0] SWF_CODE_32K = 3'h5;
    localparam logic [2:0] SWF_RESET_CODE = SWF_CODE_8K;

    // ----------------------------------------------------------------
    // output frequency thresholds, units of 0.1 Hz
    // ----------------------------------------------------------------
    localparam logic [15:0] SWF_LF_UP_32K = 16'h005A;
    localparam logic [15:0] SWF_LF_UP_24K = 16'h0046;
    localparam logic [15:0] SWF_LF_UP_16K = 16'h0032;
    localparam logic [15:0] SWF_LF_UP_12K = 16'h001E;
    localparam logic [15:0] SWF_LF_DN_32K = 16'h0046;
    localparam logic [15:0] SWF_LF_DN_24K = 16'h0032;
    localparam logic [15:0] SWF_LF_DN_16K = 16'h001E;
    localparam logic [15:0] SWF_LF_DN_12K = 16'h000A;

    // ----------------------------------------------------------------
    // motor current thresholds, units of 0.01 A; percent-of-rated factors in percent
    // ----------------------------------------------------------------
    localparam logic [15:0] SWF_CUR_TRIP = 16'h0415;
    localparam logic [15:0] SWF_CUR_MID = 16'h02F8;
    localparam logic [15:0] SWF_CUR_FULL = 16'h029E;
    localparam logic [7:0] SWF_PCT_TRIP = 8'h8C;
    localparam logic [7:0] SWF_PCT_BACK = 8'h6E;
    localparam logic [7:0] SWF_PCT_UNIT = 8'h64;

    // ----------------------------------------------------------------
    // heatsink thresholds, units of 0.1 degC
    // ----------------------------------------------------------------
    localparam logic [15:0] SWF_TEMP_BASE = 16'h0320;
    localparam logic [15:0] SWF_TEMP_STEP = 16'h0032;
    localparam logic [15:0] SWF_TEMP_HYST = 16'h0014;

    typedef enum {
        SWF_CUR_AT_SET,
        SWF_CUR_AT_8K,
        SWF_CUR_AT_24K
    } swf_cur_state_type;

    function automatic logic swf_lf_applies(input logic [2:0] code);
        swf_lf_applies = (code >= SWF_CODE_12K) && (code <= SWF_CODE_32K);
    endfunction

    function automatic logic [15:0] swf_lf_up(input logic [2:0] code);
        case (code)
            SWF_CODE_32K: swf_lf_up = SWF_LF_UP_32K;
            SWF_CODE_24K: swf_lf_up = SWF_LF_UP_24K;
            SWF_CODE_16K: swf_lf_up = SWF_LF_UP_16K;
            default: swf_lf_up = SWF_LF_UP_12K;
        endcase
    endfunction

    function automatic logic [15:0] swf_lf_dn(input logic [2:0] code);
        case (code)
            SWF_CODE_32K: swf_lf_dn = SWF_LF_DN_32K;
            SWF_CODE_24K: swf_lf_dn = SWF_LF_DN_24K;
            SWF_CODE_16K: swf_lf_dn = SWF_LF_DN_16K;
            default: swf_lf_dn = SWF_LF_DN_12K;
        endcase
    endfunction

endpackage

// File: swf_stage_model.sv
// power stage model: reports requested speed and load current with one cycle of lag
`timescale 1ns/1ps
`default_nettype none
module swf_stage_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // requests from the bench
    input wire logic [15:0] freq_req_i,
    input wire logic [15:0] cur_req_i,
    // measurements
    output logic [15:0] out_freq_o,
    output logic [15:0] motor_cur_o
);
    // a real current sense never answers in the same cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_freq_o <= 16'h0000;
            motor_cur_o <= 16'h0000;
        end else begin
            out_freq_o <= freq_req_i;
            motor_cur_o <= cur_req_i;
        end
    end
endmodule
`default_nettype wire

// File: test_switching_freq_derating.sv
// self-checking bench for the switching frequency derating block
`timescale 1ns/1ps
`default_nettype none
module test_switching_freq_derating;
    import swf_pkg::*;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic [2:0] set_code = 3'h0;
    logic variant = 1'b0;
    logic [15:0] rated = 16'h0000;
    logic [15:0] freq_req = 16'h0000;
    logic [15:0] cur_req = 16'h0000;
    logic [15:0] temp = 16'h0000;
    logic [15:0] out_freq;
    logic [15:0] motor_cur;
    logic [2:0] eff_code_o;
    logic lf_reduced_o;
    logic cur_reduced_o;
    logic [2:0] temp_level_o;
    int fails = 0;
    int n_tests = 0;
    bit m_lf;
    int m_cs;
    bit [1:0] m_hot;
    int m_lvl;
    always #12.5 clk_i = ~clk_i;
    swf_stage_model stage (.clk_i(clk_i), .reset_n_i(reset_n_i), .freq_req_i(freq_req),
        .cur_req_i(cur_req), .out_freq_o(out_freq), .motor_cur_o(motor_cur));
    swf_derate uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .set_code_i(set_code),
        .variant_i(variant), .rated_cur_i(rated), .out_freq_i(out_freq),
        .motor_cur_i(motor_cur), .temp_i(temp), .eff_code_o(eff_code_o),
        .lf_reduced_o(lf_reduced_o), .cur_reduced_o(cur_reduced_o),
        .temp_level_o(temp_level_o));
    // ----------------------------------------------------------------
    // reference model
    // ----------------------------------------------------------------
    function automatic int thr(input int c, input bit up);
        case (c)
            5: thr = up ? 90 : 70;
            4: thr = up ? 70 : 50;
            3: thr = up ? 50 : 30;
            default: thr = up ? 30 : 10;
        endcase
    endfunction
    // heatsink levels keep their own hysteresis, so a frozen enable leaves them as they were
    function automatic void m_step(input int c, input bit v, input int r, input int f, input int i,
            input int t);
        int lo;
        for (int g = 0; g < 2; g++) begin
            lo = int'(SWF_TEMP_BASE) + g * int'(SWF_TEMP_STEP);
            if (t > lo) m_hot[g] = 1'b1;
            else if (t < lo - int'(SWF_TEMP_HYST)) m_hot[g] = 1'b0;
        end
        m_lvl = int'(m_hot[0]) + int'(m_hot[1]);
        if (f > thr(c, 1)) m_lf = 0;
        else if (f < thr(c, 0)) m_lf = 1;
        if (v) begin
            if (m_cs == 0 && i > 1045) m_cs = 1;
            else if (m_cs == 1 && i < 760) m_cs = (c == 5) ? 2 : 0;
            else if (m_cs == 2 && i > 1045) m_cs = 1;
            else if (m_cs == 2 && i < 670) m_cs = 0;
        end else begin
            if (m_cs == 0 && i * 100 > r * 140) m_cs = 1;
            else if (m_cs != 0 && i * 100 < r * 110) m_cs = 0;
        end
    endfunction
    function automatic logic [2:0] exp_code(input int c, input int lvl);
        int e;
        e = c;
        if (m_lf && c >= 2 && e > 1) e = 1;
        if (m_cs == 1 && e > 1) e = 1;
        if (m_cs == 2 && e > 4) e = 4;
        if (c - lvl < e) e = (c > lvl) ? c - lvl : 0;
        exp_code = e[2:0];
    endfunction
    // ----------------------------------------------------------------
    // compare, drive and finish
    // ----------------------------------------------------------------
    task automatic chk3(input string nm, input logic [2:0] exp, input logic [2:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic chk1(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0b seen %0b", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one measurement lag plus two design edges settle any vector in three of the four edges
    task automatic apply(input int c, input bit v, input int r, input int f, input int i,
            input int t, input bit ce = 1'b1);
        ce_i = ce;
        set_code = c[2:0];
        variant = v;
        rated = r[15:0];
        freq_req = f[15:0];
        cur_req = i[15:0];
        temp = t[15:0];
        repeat (4) @(posedge clk_i);
        #2;
        if (ce) begin
            m_step(c, v, r, f, i, t);
            m_step(c, v, r, f, i, t);
        end
        chk3("eff_code", exp_code(c, m_lvl), eff_code_o);
        chk1("lf_reduced", m_lf && c >= 2, lf_reduced_o);
        chk1("cur_reduced", m_cs != 0, cur_reduced_o);
        chk3("temp_level", m_lvl[2:0], temp_level_o);
    endtask
    task automatic do_reset;
        reset_n_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #2;
        chk3("eff_code", 3'h1, eff_code_o);
        chk1("lf_reduced", 1'b0, lf_reduced_o);
        chk1("cur_reduced", 1'b0, cur_reduced_o);
        chk3("temp_level", 3'h0, temp_level_o);
        m_lf = 1;
        m_cs = 0;
        m_hot = 2'b00;
        m_lvl = 0;
        reset_n_i = 1'b1;
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h53fb82cb));
        #2;
        do_reset();
        for (int c = 0; c < 6; c++) apply(c, 1, 0, 1000, 0, 0);
        for (int c = 0; c < 2; c++) apply(c, 1, 0, 0, 0, 0);
        for (int c = 2; c < 6; c++) begin
            apply(c, 1, 0, 1000, 0, 0);
            apply(c, 1, 0, thr(c, 0), 0, 0);
            apply(c, 1, 0, thr(c, 0) - 1, 0, 0);
            apply(c, 1, 0, thr(c, 1), 0, 0);
            apply(c, 1, 0, thr(c, 1) + 1, 0, 0);
        end
        apply(5, 1, 0, 1000, 1045, 0);
        apply(5, 1, 0, 1000, 1100, 0);
        apply(5, 1, 0, 1000, 700, 0);
        apply(5, 1, 0, 1000, 1100, 0);
        apply(5, 1, 0, 1000, 700, 0);
        apply(5, 1, 0, 1000, 670, 0);
        apply(5, 1, 0, 1000, 600, 0);
        apply(3, 1, 0, 1000, 1100, 0);
        apply(3, 1, 0, 1000, 760, 0);
        apply(3, 1, 0, 1000, 759, 0);
        apply(4, 0, 800, 1000, 1120, 0);
        apply(4, 0, 800, 1000, 1121, 0);
        apply(4, 0, 800, 1000, 880, 0);
        apply(4, 0, 800, 1000, 879, 0);
        apply(5, 1, 0, 1000, 0, 1200);
        apply(5, 1, 0, 1000, 1100, 1200);
        apply(5, 1, 0, 1000, 0, 0, 1'b0);
        apply(5, 1, 0, 1000, 0, 0);
        apply(5, 1, 0, 0, 0, 0, 1'b0);
        apply(5, 1, 0, 0, 0, 0);
        for (int b = 0; b < 16; b++) begin
            int c;
            int r;
            c = 2 + ($urandom % 4);
            r = 700 + ($urandom % 200);
            apply(c, b[0], r, 1000, 0, 0);
            apply(c, b[0], r, 1000, 0, 0);
            for (int k = 0; k < 12; k++) begin
                apply(c, b[0], r, $urandom % 120, b[0] ? 600 + ($urandom % 550) :
                    $urandom % 1400, 700 + ($urandom % 200));
            end
        end
        do_reset();
        apply(2, 0, 800, 20, 0, 0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
